// file: core/dit_debounce.sv
// edge qualifier for the count input, with optional stability filter
module dit_debounce
	import dit_pkg::*;
#(
	parameter int DEB_CYC = DIT_DEB_CYC_DEF
)
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// control
	input  wire logic deb_en_i,
	input  wire logic level_i,
	// qualified rising edge
	output logic      edge_o
);

	typedef struct packed {
		logic                   filt;
		logic                   cand;
		logic [DIT_TIMER_W-1:0] cnt;
		logic                   edge_p;
	} dit_deb_st_type;

	localparam logic [DIT_TIMER_W-1:0] DEB_LAST = DIT_TIMER_W'(DEB_CYC - 1);

	dit_deb_st_type st_q; // registered state
	dit_deb_st_type st_d; // next state

	// with filtering on, the filtered level follows the input only after it stayed put long enough
	always_comb begin
		st_d        = st_q;
		st_d.edge_p = 1'b0;
		if (!deb_en_i) begin
			// no filtering: every rising edge counts
			st_d.filt   = level_i;
			st_d.cand   = level_i;
			st_d.cnt    = '0;
			st_d.edge_p = level_i & ~st_q.filt;
		end else if (level_i != st_q.cand) begin
			// input moved: restart the stability window
			st_d.cand = level_i;
			st_d.cnt  = '0;
		end else if (st_q.cand != st_q.filt) begin
			if (st_q.cnt == DEB_LAST) begin
				st_d.filt   = st_q.cand;
				st_d.edge_p = st_q.cand;
			end else begin
				st_d.cnt = st_q.cnt + 1'b1;
			end
		end
	end

	// register state
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign edge_o = st_q.edge_p;

endmodule : dit_debounce

// file: core/dit_pkg.sv
package dit_pkg;

	// register byte offsets on the apb bus
	localparam logic [7:0] DIT_OFF_LINE_MASK  = 8'h00; // digital line mask
	localparam logic [7:0] DIT_OFF_LINE_VAL   = 8'h04; // line value, commits
	localparam logic [7:0] DIT_OFF_LINE_RD    = 8'h08; // line readback
	localparam logic [7:0] DIT_OFF_RLY_MASK   = 8'h0C; // relay mask
	localparam logic [7:0] DIT_OFF_RLY_VAL    = 8'h10; // relay value, commits
	localparam logic [7:0] DIT_OFF_RLY_RD     = 8'h14; // relay readback
	localparam logic [7:0] DIT_OFF_COUNT      = 8'h18; // count load / read
	localparam logic [7:0] DIT_OFF_SETUP      = 8'h1C; // direction, debounce
	localparam logic [7:0] DIT_OFF_TRIG_IN    = 8'h20; // trigger input state
	localparam logic [7:0] DIT_OFF_TRIG_OUT   = 8'h24; // write pulses output
	localparam logic [7:0] DIT_OFF_ALARM      = 8'h28; // alarm force
	localparam logic [7:0] DIT_OFF_DEV_RESET  = 8'h2C; // write restores defaults

	// field layout
	localparam int DIT_LINE_W    = 20;
	localparam int DIT_RLY_W     = 8;
	localparam int DIT_CNT_W     = 32;
	localparam int DIT_SETUP_DIR = 0;
	localparam int DIT_SETUP_DEB = 1;

	// reset values
	localparam logic [DIT_LINE_W-1:0] DIT_LINE_RST = 20'h00000;
	localparam logic [DIT_RLY_W-1:0]  DIT_RLY_RST  = 8'hFF; // all relays reset
	localparam logic [DIT_CNT_W-1:0]  DIT_CNT_RST  = 32'h00000000;
	localparam logic                  DIT_DIR_RST  = 1'b1; // counting up
	localparam logic                  DIT_DEB_RST  = 1'b0;

	// timing
	localparam int DIT_CLK_MHZ     = 200;
	localparam int DIT_TRIG_US     = 200;
	localparam int DIT_TRIG_CYC    = DIT_TRIG_US * DIT_CLK_MHZ;
	localparam int DIT_TIMER_W     = 16;
	localparam int DIT_DEB_CYC_DEF = 1000;

	// trigger output sequencer states
	typedef enum logic [0:0] {
		DIT_TRIG_IDLE,
		DIT_TRIG_PULSE
	} dit_trig_state_type;

	// apb request bundle
	typedef struct packed {
		logic        sel;
		logic        enable;
		logic        write;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} dit_apb_req_type;

endpackage : dit_pkg

// file: core/dit_sync.sv
// two-flop synchroniser; the first stage feeds only the second
module dit_sync
	import dit_pkg::*;
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// data
	input  wire logic d_i,
	output logic      q_o
);

	typedef struct packed {
		logic meta;
		logic stable;
	} dit_sync_st_type;

	dit_sync_st_type st_q; // registered state
	dit_sync_st_type st_d; // next state

	// shift the input through both stages
	always_comb begin
		st_d        = st_q;
		st_d.meta   = d_i;
		st_d.stable = st_q.meta;
	end

	// both stages clear to low
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign q_o = st_q.stable;

endmodule : dit_sync

// file: core/dit_top.sv
module dit_top
	import dit_pkg::*;
#(
	parameter int TRIG_CYC = DIT_TRIG_CYC,
	parameter int DEB_CYC  = DIT_DEB_CYC_DEF
)
(
	// clock and reset
	input  wire logic                  core_clk_i,
	input  wire logic                  arst_n_i,
	// apb slave
	input  wire logic                  psel_i,
	input  wire logic                  penable_i,
	input  wire logic                  pwrite_i,
	input  wire logic [7:0]            paddr_i,
	input  wire logic [31:0]           pwdata_i,
	output logic      [31:0]           prdata_o,
	output logic                       pready_o,
	output logic                       pslverr_o,
	// digital lines and relays
	output logic      [DIT_LINE_W-1:0] line_o,
	input  wire logic [DIT_LINE_W-1:0] line_i,
	output logic      [DIT_RLY_W-1:0]  relay_o,
	// chassis signals
	input  wire logic                  count_in_i,
	input  wire logic                  trig_in_i,
	output logic                       trig_out_n_o,
	output logic                       alarm_n_o
);

	// whole register state of the block
	typedef struct packed {
		logic [DIT_LINE_W-1:0]  line_mask;
		logic [DIT_LINE_W-1:0]  line_val;
		logic [DIT_RLY_W-1:0]   rly_mask;
		logic [DIT_RLY_W-1:0]   rly_val;
		logic [DIT_CNT_W-1:0]   count;
		logic                   dir_up;
		logic                   deb_on;
		logic                   alarm_on;
		dit_trig_state_type     trig_st;
		logic [DIT_TIMER_W-1:0] trig_cnt;
		logic [31:0]            rdata;
	} dit_st_type;

	localparam logic [DIT_TIMER_W-1:0] TRIG_LAST =
		DIT_TIMER_W'(TRIG_CYC - 1);

	logic            rst_sync_q1; // reset release stage one
	logic            rst_sync_q2; // reset release stage two
	logic            rst_n;       // released reset used everywhere
	logic            cnt_sync;    // synchronised count input
	logic            trig_sync;   // synchronised trigger input
	logic            cnt_edge;    // qualified count pulse
	dit_apb_req_type req;         // bundled bus request
	logic            wr_acc;      // write access phase
	logic            rd_acc;      // read setup phase
	logic            mapped;      // address decodes to a register
	dit_st_type      st_q;        // registered state
	dit_st_type      st_d;        // next state

	// merge masked value into held bits, shared by lines and relays
	function automatic logic [DIT_LINE_W-1:0] merge(
		input logic [DIT_LINE_W-1:0] held,
		input logic [DIT_LINE_W-1:0] mask,
		input logic [DIT_LINE_W-1:0] val
	);
		merge = (held & ~mask) | (val & mask);
	endfunction : merge

	// hold reset asserted until two clean edges after release
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_sync_q1 <= 1'b0;
			rst_sync_q2 <= 1'b0;
		end else begin
			rst_sync_q1 <= 1'b1;
			rst_sync_q2 <= rst_sync_q1;
		end
	end
	assign rst_n = rst_sync_q2;

	// both asynchronous chassis inputs are brought in by two flops
	dit_sync u_cnt_sync (
		.clk_i   (core_clk_i),
		.rst_n_i (rst_n),
		.d_i     (count_in_i),
		.q_o     (cnt_sync)
	);
	dit_sync u_trig_sync (
		.clk_i   (core_clk_i),
		.rst_n_i (rst_n),
		.d_i     (trig_in_i),
		.q_o     (trig_sync)
	);

	// debounce or pass straight, per setup bit
	dit_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
		.clk_i    (core_clk_i),
		.rst_n_i  (rst_n),
		.deb_en_i (st_q.deb_on),
		.level_i  (cnt_sync),
		.edge_o   (cnt_edge)
	);

	// bus decode; the slave always answers in the first access cycle
	assign req.sel    = psel_i;
	assign req.enable = penable_i;
	assign req.write  = pwrite_i;
	assign req.addr   = paddr_i;
	assign req.wdata  = pwdata_i;
	assign wr_acc = req.sel & req.enable & req.write;
	assign rd_acc = req.sel & ~req.enable & ~req.write;
	always_comb begin
		case (req.addr)
			DIT_OFF_LINE_MASK, DIT_OFF_LINE_VAL, DIT_OFF_LINE_RD,
			DIT_OFF_RLY_MASK, DIT_OFF_RLY_VAL, DIT_OFF_RLY_RD,
			DIT_OFF_COUNT, DIT_OFF_SETUP, DIT_OFF_TRIG_IN,
			DIT_OFF_TRIG_OUT, DIT_OFF_ALARM,
			DIT_OFF_DEV_RESET: mapped = 1'b1;
			default:           mapped = 1'b0;
		endcase
	end

	// next-state logic for registers, counter and trigger pulse
	always_comb begin
		st_d = st_q;

		// counting steps on each qualified pulse; a load in the same cycle wins
		if (cnt_edge) begin
			if (st_q.dir_up) begin
				st_d.count = st_q.count + 1'b1;
			end else begin
				// plain subtraction wraps through zero
				st_d.count = st_q.count - 1'b1;
			end
		end

		// trigger output sequencer
		case (st_q.trig_st)
			DIT_TRIG_IDLE: begin
				st_d.trig_cnt = '0;
			end
			DIT_TRIG_PULSE: begin
				if (st_q.trig_cnt == TRIG_LAST) begin
					st_d.trig_st  = DIT_TRIG_IDLE;
					st_d.trig_cnt = '0;
				end else begin
					st_d.trig_cnt = st_q.trig_cnt + 1'b1;
				end
			end
			default: begin
				st_d.trig_st = DIT_TRIG_IDLE;
			end
		endcase

		// register writes at the access phase
		if (wr_acc) begin
			case (req.addr)
				DIT_OFF_LINE_MASK: begin
					st_d.line_mask = req.wdata[DIT_LINE_W-1:0];
				end
				DIT_OFF_LINE_VAL: begin
					st_d.line_val = merge(st_q.line_val, st_q.line_mask,
						req.wdata[DIT_LINE_W-1:0]);
				end
				DIT_OFF_RLY_MASK: begin
					st_d.rly_mask = req.wdata[DIT_RLY_W-1:0];
				end
				DIT_OFF_RLY_VAL: begin
					// relays sit in the low bits of the shared merge
					st_d.rly_val = DIT_RLY_W'(merge(
						DIT_LINE_W'(st_q.rly_val),
						DIT_LINE_W'(st_q.rly_mask),
						DIT_LINE_W'(req.wdata[DIT_RLY_W-1:0])));
				end
				DIT_OFF_COUNT: begin
					st_d.count = req.wdata;
				end
				DIT_OFF_SETUP: begin
					st_d.dir_up = req.wdata[DIT_SETUP_DIR];
					st_d.deb_on = req.wdata[DIT_SETUP_DEB];
				end
				DIT_OFF_TRIG_OUT: begin
					// a retrigger during a pulse restarts the full width
					st_d.trig_st  = DIT_TRIG_PULSE;
					st_d.trig_cnt = '0;
				end
				DIT_OFF_ALARM: begin
					st_d.alarm_on = req.wdata[0];
				end
				DIT_OFF_DEV_RESET: begin
					// settings back to defaults; counter and pulse kept
					st_d.line_mask = DIT_LINE_RST;
					st_d.line_val  = DIT_LINE_RST;
					st_d.rly_mask  = '0;
					st_d.rly_val   = DIT_RLY_RST;
					st_d.dir_up    = DIT_DIR_RST;
					st_d.deb_on    = DIT_DEB_RST;
					st_d.alarm_on  = 1'b0;
				end
				default: begin
				end
			endcase
		end

		// read data captured in setup so it is stable in access
		if (rd_acc) begin
			case (req.addr)
				DIT_OFF_LINE_MASK: st_d.rdata = 32'(st_q.line_mask);
				DIT_OFF_LINE_VAL:  st_d.rdata = 32'(st_q.line_val);
				DIT_OFF_LINE_RD:   st_d.rdata = 32'(line_i);
				DIT_OFF_RLY_MASK:  st_d.rdata = 32'(st_q.rly_mask);
				DIT_OFF_RLY_VAL,
				DIT_OFF_RLY_RD:    st_d.rdata = 32'(st_q.rly_val);
				DIT_OFF_COUNT:     st_d.rdata = st_q.count;
				DIT_OFF_SETUP: begin
					st_d.rdata = '0;
					st_d.rdata[DIT_SETUP_DIR] = st_q.dir_up;
					st_d.rdata[DIT_SETUP_DEB] = st_q.deb_on;
				end
				// concatenation keeps the inversion to one bit
				DIT_OFF_TRIG_IN:   st_d.rdata = {31'h00000000, ~trig_sync};
				DIT_OFF_ALARM:     st_d.rdata = 32'(st_q.alarm_on);
				default:           st_d.rdata = '0;
			endcase
		end
	end

	// single state register
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_q           <= '0;
			st_q.line_mask <= DIT_LINE_RST;
			st_q.line_val  <= DIT_LINE_RST;
			st_q.rly_val   <= DIT_RLY_RST;
			st_q.count     <= DIT_CNT_RST;
			st_q.dir_up    <= DIT_DIR_RST;
			st_q.deb_on    <= DIT_DEB_RST;
			st_q.trig_st   <= DIT_TRIG_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs straight from flops, except pready_o which is tied high and pslverr_o which is decoded from the bus inputs
	assign line_o       = st_q.line_val;
	assign relay_o      = st_q.rly_val;
	assign trig_out_n_o = (st_q.trig_st != DIT_TRIG_PULSE);
	assign alarm_n_o    = ~st_q.alarm_on;
	assign prdata_o     = st_q.rdata;
	assign pready_o     = 1'b1;
	assign pslverr_o    = req.sel & req.enable & ~mapped;

	// masked line write touches only masked bits
	chk_line_masked: assert property (@(posedge core_clk_i)
		disable iff (!rst_n)
		(wr_acc && req.addr == DIT_OFF_LINE_VAL) |=>
		((line_o & ~$past(st_q.line_mask)) ==
		 ($past(line_o) & ~$past(st_q.line_mask))))
		else $error("unmasked digital line changed");

	chk_line_value: assert property (@(posedge core_clk_i)
		disable iff (!rst_n)
		(wr_acc && req.addr == DIT_OFF_LINE_VAL) |=>
		((line_o & $past(st_q.line_mask)) ==
		 ($past(req.wdata[DIT_LINE_W-1:0]) & $past(st_q.line_mask))))
		else $error("masked line did not take value");

	chk_relay_value: assert property (@(posedge core_clk_i)
		disable iff (!rst_n)
		(wr_acc && req.addr == DIT_OFF_RLY_VAL) |=>
		((relay_o & $past(st_q.rly_mask)) ==
		 ($past(req.wdata[DIT_RLY_W-1:0]) & $past(st_q.rly_mask))))
		else $error("masked relay did not take value");

	chk_relay_masked: assert property (@(posedge core_clk_i)
		disable iff (!rst_n)
		(wr_acc && req.addr == DIT_OFF_RLY_VAL) |=>
		((relay_o & ~$past(st_q.rly_mask)) ==
		 ($past(relay_o) & ~$past(st_q.rly_mask))))
		else $error("unmasked relay changed");

	chk_count_load: assert property (@(posedge core_clk_i)
		disable iff (!rst_n)
		(wr_acc && req.addr == DIT_OFF_COUNT) |=>
		(st_q.count == $past(req.wdata)))
		else $error("count load not taken");

	chk_count_down: assert property (@(posedge core_clk_i)
		disable iff (!rst_n)
		(cnt_edge && !st_q.dir_up && !wr_acc) |=>
		(st_q.count == $past(st_q.count) - 32'h00000001))
		else $error("down count did not wrap or step");

	chk_count_up: assert property (@(posedge core_clk_i)
		disable iff (!rst_n)
		(cnt_edge && st_q.dir_up && !wr_acc) |=>
		(st_q.count == $past(st_q.count) + 32'h00000001))
		else $error("up count wrong");

	chk_count_hold: assert property (@(posedge core_clk_i)
		disable iff (!rst_n)
		(!cnt_edge && !wr_acc) |=> $stable(st_q.count))
		else $error("count moved with no pulse");

	// the pulse stays low and its timer steps by one until the last count
	chk_trig_width: assert property (@(posedge core_clk_i)
		disable iff (!rst_n)
		(!trig_out_n_o && st_q.trig_cnt != TRIG_LAST && !wr_acc) |=>
		(!trig_out_n_o &&
		 st_q.trig_cnt == $past(st_q.trig_cnt) + 1'b1))
		else $error("trigger pulse too short");

	chk_trig_end: assert property (@(posedge core_clk_i)
		disable iff (!rst_n)
		(st_q.trig_st == DIT_TRIG_PULSE && st_q.trig_cnt == TRIG_LAST
		 && !wr_acc) |=> trig_out_n_o)
		else $error("trigger pulse not ended");

	chk_alarm_level: assert property (@(posedge core_clk_i)
		disable iff (!rst_n)
		(wr_acc && req.addr == DIT_OFF_ALARM) |=>
		(alarm_n_o == !$past(req.wdata[0])))
		else $error("alarm level wrong");

endmodule : dit_top

// file: dv/dit_far_model.sv
// chassis side: wiring for the lines and a pulse source for the count input
module dit_far_model
	import dit_pkg::*;
(
	// clock
	input  wire logic                  clk_i,
	// line wiring
	input  wire logic [DIT_LINE_W-1:0] line_drv_i,
	output logic      [DIT_LINE_W-1:0] line_o,
	// pulse source
	input  wire logic                  go_i,
	input  wire logic [7:0]            width_i,
	output logic                       count_o,
	output logic                       busy_o
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [8:0] left_q  = 9'd0; // cycles left in the pulse period
	logic       count_q = 1'b0; // pulse level, idle low

	// lines wired straight back, as an unloaded connector would be
	assign line_o  = line_drv_i;
	assign busy_o  = (left_q != 9'd0);
	assign count_o = count_q;

	// high for width cycles, then low for width cycles
	always @(posedge clk_i) begin
		if (go_i) begin
			left_q  <= {width_i, 1'b0};
			count_q <= 1'b1;
		end else if (left_q != 9'd0) begin
			left_q  <= left_q - 9'd1;
			count_q <= (left_q - 9'd1) > {1'b0, width_i};
		end
	end
endmodule : dit_far_model

// file: dv/dit_top_tb.sv
// scenario bench for the digital io, count and trigger block
module dit_top_tb;
	import dit_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int TRIG = 20; // short pulse width for simulation
	localparam int DEB  = 4;  // short debounce for simulation

	logic                  clk, arst_n, psel, pen, pwr, pready, pslverr;
	logic [7:0]            paddr;
	logic [31:0]           pwdata, prdata, rdat;
	logic                  rerr, count_in, trig_in, trig_out_n, alarm_n;
	logic                  go, busy;
	logic [7:0]            width;
	logic [DIT_LINE_W-1:0] line_drv, line_back;
	logic [DIT_RLY_W-1:0]  relay;
	int                    bad_count, tests_run, cycles;

	dit_top #(.TRIG_CYC(TRIG), .DEB_CYC(DEB)) dit_top_i (
		.core_clk_i(clk), .arst_n_i(arst_n), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .line_o(line_drv), .line_i(line_back),
		.relay_o(relay), .count_in_i(count_in), .trig_in_i(trig_in),
		.trig_out_n_o(trig_out_n), .alarm_n_o(alarm_n));

	dit_far_model dit_far_model_i (
		.clk_i(clk), .line_drv_i(line_drv), .line_o(line_back),
		.go_i(go), .width_i(width), .count_o(count_in), .busy_o(busy));

	// free running clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// verdict and end of run
	task final_report;
		if (bad_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report

	// hang guard, well above the length of all scenarios
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			bad_count++;
			final_report();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("BAD at %0t got %h expected %h", $time, got, exp);
			bad_count++;
		end
	endtask : chk

	// one apb transfer; request held until pready is seen high
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel   <= 1'b1;
		pwr    <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		pen  <= 1'b0;
		@(posedge clk); // let the write land before outputs are looked at
	endtask : apb

	// one pulse of the given width, then its low phase and sync latency
	task pulse(input logic [7:0] w);
		@(posedge clk);
		go    <= 1'b1;
		width <= w;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		while (busy) begin
			@(posedge clk);
		end
		repeat (6) @(posedge clk);
	endtask : pulse

	task t_reset;
		chk(line_drv, 32'h0);
		chk(relay, 32'hFF);
		chk(alarm_n, 32'h1);
		chk(trig_out_n, 32'h1);
		apb(1'b0, DIT_OFF_SETUP, 32'h0);
		chk(rdat, 32'h1);
	endtask : t_reset

	task t_lines;
		apb(1'b1, DIT_OFF_LINE_MASK, 32'h0000C);
		apb(1'b1, DIT_OFF_LINE_VAL, 32'h0000C);
		chk(line_drv, 32'h0000C);
		apb(1'b1, DIT_OFF_LINE_MASK, 32'h80001);
		apb(1'b1, DIT_OFF_LINE_VAL, 32'hFFFFF);
		chk(line_drv, 32'h8000D);
		apb(1'b0, DIT_OFF_LINE_RD, 32'h0);
		chk(rdat, 32'h8000D);
		apb(1'b1, DIT_OFF_LINE_MASK, 32'hFFFFF);
		apb(1'b1, DIT_OFF_LINE_VAL, 32'h0);
		chk(line_drv, 32'h0);
	endtask : t_lines

	task t_relays;
		apb(1'b1, DIT_OFF_RLY_MASK, 32'h06);
		apb(1'b1, DIT_OFF_RLY_VAL, 32'h00);
		chk(relay, 32'hF9);
		apb(1'b0, DIT_OFF_RLY_RD, 32'h0);
		chk(rdat, 32'hF9);
		apb(1'b1, DIT_OFF_RLY_VAL, 32'h02);
		chk(relay, 32'hFB);
	endtask : t_relays

	task t_count;
		apb(1'b1, DIT_OFF_COUNT, 32'hFFFFFFFE);
		pulse(8'd2);
		pulse(8'd2);
		apb(1'b0, DIT_OFF_COUNT, 32'h0);
		chk(rdat, 32'h0);
		apb(1'b0, DIT_OFF_COUNT, 32'h0);
		chk(rdat, 32'h0);
		apb(1'b1, DIT_OFF_SETUP, 32'h0);
		pulse(8'd2);
		apb(1'b0, DIT_OFF_COUNT, 32'h0);
		chk(rdat, 32'hFFFFFFFF);
		apb(1'b1, DIT_OFF_SETUP, 32'h2);
		apb(1'b0, DIT_OFF_SETUP, 32'h0);
		chk(rdat, 32'h2);
		pulse(8'd2); // shorter than the filter: ignored
		apb(1'b0, DIT_OFF_COUNT, 32'h0);
		chk(rdat, 32'hFFFFFFFF);
		pulse(8'd8);
		apb(1'b0, DIT_OFF_COUNT, 32'h0);
		chk(rdat, 32'hFFFFFFFE);
	endtask : t_count

	task t_trig_in;
		@(posedge clk);
		trig_in <= 1'b0;
		repeat (4) @(posedge clk);
		apb(1'b0, DIT_OFF_TRIG_IN, 32'h0);
		chk(rdat, 32'h1);
		trig_in <= 1'b1;
		repeat (4) @(posedge clk);
		apb(1'b0, DIT_OFF_TRIG_IN, 32'h0);
		chk(rdat, 32'h0);
	endtask : t_trig_in

	task t_trig_out;
		int n;
		int k;
		n = 0;
		k = 0;
		apb(1'b1, DIT_OFF_TRIG_OUT, 32'h0);
		while (trig_out_n !== 1'b0 && k < 10) begin
			@(posedge clk);
			k++;
		end
		while (trig_out_n === 1'b0 && n < 100) begin
			@(posedge clk);
			n++;
		end
		chk(n, TRIG);
	endtask : t_trig_out

	task t_alarm_bad;
		apb(1'b1, DIT_OFF_ALARM, 32'h1);
		chk(alarm_n, 32'h0);
		apb(1'b1, DIT_OFF_ALARM, 32'h0);
		chk(alarm_n, 32'h1);
		apb(1'b0, 8'h40, 32'h0); // unmapped place
		chk({rerr, rdat[30:0]}, 32'h80000000);
	endtask : t_alarm_bad

	task t_dev_reset;
		apb(1'b1, DIT_OFF_LINE_VAL, 32'h00005);
		apb(1'b1, DIT_OFF_ALARM, 32'h1);
		apb(1'b1, DIT_OFF_COUNT, 32'h00001234);
		apb(1'b1, DIT_OFF_DEV_RESET, 32'h0);
		chk(line_drv, 32'h0);
		chk(relay, 32'hFF);
		chk(alarm_n, 32'h1);
		apb(1'b0, DIT_OFF_SETUP, 32'h0);
		chk(rdat, 32'h1);
		apb(1'b0, DIT_OFF_COUNT, 32'h0);
		chk(rdat, 32'h1234);
		apb(1'b1, DIT_OFF_LINE_VAL, 32'hFFFFF);
		chk(line_drv, 32'h0);
		apb(1'b1, DIT_OFF_RLY_VAL, 32'h00);
		chk(relay, 32'hFF);
	endtask : t_dev_reset

	// main sequence
	initial begin
		{arst_n, psel, pen, pwr, go} = 5'b0;
		{paddr, pwdata, width} = '0;
		{bad_count, tests_run} = '0;
		trig_in = 1'b1;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_lines();
		t_relays();
		t_count();
		t_trig_in();
		t_trig_out();
		t_alarm_bad();
		t_dev_reset();
		final_report();
	end
endmodule : dit_top_tb
